//--- include/pqm_pkg.sv
// Constants and types shared by the packet queue memory manager
package pqm_pkg;
  localparam int PKT_W = 6;
  localparam int NPKT = 64;
  localparam int PAGE_W = 3;
  localparam int OFF_W = 6;
  localparam int SEQ_W = PAGE_W + OFF_W;
  localparam int PHYS_W = PKT_W + SEQ_W;
  localparam int PG_W = 4;
  localparam int FREE_W = 10;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int BYTES_W = 12;
  localparam int PAGE_SHIFT = 8;
  localparam logic [FREE_W-1:0] TOTAL_PAGES = 10'h200;
  localparam logic [PG_W-1:0] MAX_PKT_PAGES = 4'h8;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ALLOC_RES = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PACKET_NUMBER = 8'h08;
  localparam logic [ADDR_W-1:0] REG_FIFO_PORTS = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h10;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h14;
  localparam logic [ADDR_W-1:0] REG_RESERVE = 8'h18;
  localparam logic [ADDR_W-1:0] REG_MEMINFO = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_TX_ACK = 8'h20;
  // Command field and codes
  localparam int CMD_LSB = 0;
  localparam int CMD_BYTES_LSB = 16;
  localparam logic [3:0] CMD_ALLOC = 4'h1;
  localparam logic [3:0] CMD_RELEASE = 4'h2;
  localparam logic [3:0] CMD_ENQ_TX = 4'h3;
  localparam logic [3:0] CMD_RM_REL_RX = 4'h4;
  // Control bit positions, reset values and status field positions
  localparam int CTL_TX_EN = 0;
  localparam int CTL_RX_EN = 1;
  localparam int CTL_AUTO = 2;
  localparam int CTL_RXIE = 3;
  localparam logic [3:0] CTL_RESET = 4'h0;
  localparam logic [FREE_W-1:0] RESERVE_RESET = 10'h000;
  localparam int MEMINFO_TOTAL_LSB = 16;
  localparam int ALLOC_FAIL_BIT = 7;

  typedef enum logic [1:0] {ST_IDLE, ST_TX_STAT, ST_RX_STAT, ST_RX_CNT} pqm_fsm_t;

  typedef struct packed {
    logic wr;
    logic [PHYS_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pqm_mem_wr_t;

  typedef struct packed {
    logic [NPKT-1:0][PKT_W-1:0] mem;
    logic [PKT_W:0] wp;
    logic [PKT_W:0] rp;
  } pqm_fifo_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic alloc_done;
    logic alloc_pend;
    logic alloc_fail;
    logic [PG_W-1:0] alloc_pages;
    logic [PKT_W-1:0] alloc_res;
    logic [PKT_W-1:0] packet_number_register;
    logic [3:0] ctrl;
    logic [FREE_W-1:0] reserve;
    logic [FREE_W-1:0] free;
    logic [NPKT-1:0] used;
    logic [NPKT-1:0][PG_W-1:0] pages;
    logic rx_act;
    logic rx_pend;
    logic [PKT_W-1:0] rx_pkt;
    logic rx_crc;
    logic [DATA_W-1:0] rx_stat;
    logic [DATA_W-1:0] rx_cnt;
    logic rx_ovr_p;
    logic tx_busy;
    logic tx_pend;
    logic tx_start;
    logic tx_fatal;
    logic halt;
    logic [PKT_W-1:0] tx_pkt;
    logic [DATA_W-1:0] tx_stat;
    pqm_fsm_t st;
    pqm_mem_wr_t mem;
  } pqm_state_t;
endpackage : pqm_pkg

//--- src/pqm_fifo.sv
// Queue of packet numbers held in flip-flops
module pqm_fifo
  import pqm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [pqm_pkg::PKT_W-1:0] data_i,
  output logic [pqm_pkg::PKT_W-1:0] data_o,
  output logic empty_o,
  output logic full_o
);
  import pqm_pkg::*;

  pqm_fifo_t s_reg;
  pqm_fifo_t s_next;

  assign empty_o = (s_reg.wp == s_reg.rp);
  assign full_o = (s_reg.wp[PKT_W] != s_reg.rp[PKT_W]) &&
                  (s_reg.wp[PKT_W-1:0] == s_reg.rp[PKT_W-1:0]);
  assign data_o = s_reg.mem[s_reg.rp[PKT_W-1:0]];

  always_comb begin
    s_next = s_reg;
    if (push_i && !full_o) begin
      s_next.mem[s_reg.wp[PKT_W-1:0]] = data_i;
      s_next.wp = s_reg.wp + 1'b1;
    end
    if (pop_i && !empty_o) begin
      s_next.rp = s_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : pqm_fifo

//--- src/pqm_manager.sv
// Packet buffer manager: page allocation, transmit and receive queues
//
// Chosen here: the strobed register port and the placing of the registers.
module pqm_manager
  import pqm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [pqm_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [pqm_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [pqm_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic full_duplex_i,
  input wire logic defer_ok_i,
  output logic tx_start_o,
  output logic [pqm_pkg::PKT_W-1:0] tx_pkt_o,
  input wire logic tx_done_i,
  input wire logic tx_fatal_i,
  input wire logic [pqm_pkg::DATA_W-1:0] tx_status_i,
  input wire logic rx_start_i,
  output logic rx_active_o,
  output logic [pqm_pkg::PKT_W-1:0] rx_pkt_o,
  input wire logic rx_wr_i,
  input wire logic [pqm_pkg::SEQ_W-1:0] rx_seq_addr_i,
  input wire logic [pqm_pkg::DATA_W-1:0] rx_data_i,
  input wire logic rx_ovr_i,
  input wire logic rx_end_i,
  input wire logic rx_crc_ok_i,
  input wire logic [pqm_pkg::DATA_W-1:0] rx_status_i,
  input wire logic [pqm_pkg::DATA_W-1:0] rx_count_i,
  output pqm_pkg::pqm_mem_wr_t mem_o,
  output logic rx_overrun_o,
  output logic allocation_done_flag_o,
  output logic send_done_o,
  output logic send_queue_empty_o,
  output logic receive_packet_flag_o
);
  import pqm_pkg::*;

  pqm_state_t s_reg;
  pqm_state_t s_next;
  logic txq_push, txq_pop, txq_empty;
  logic cmpq_push, cmpq_pop, cmpq_empty;
  logic rxq_push, rxq_pop, rxq_empty;
  logic [PKT_W-1:0] txq_head, cmpq_head, rxq_head;
  logic [PKT_W-1:0] cmpq_din;
  logic [PKT_W:0] ff;
  logic rx_go;
  logic rx_fail;
  logic [PG_W-1:0] req_pages;
  logic [BYTES_W:0] bytes_up;

  function automatic logic [PKT_W:0] first_free(input logic [NPKT-1:0] used);
    logic [PKT_W:0] r;
    r = '0;
    for (int i = NPKT - 1; i >= 0; i--) begin
      if (!used[i]) begin
        r = {1'b1, PKT_W'(i)};
      end
    end
    return r;
  endfunction : first_free

  function automatic pqm_state_t rel_pkt(input pqm_state_t x, input logic [PKT_W-1:0] p);
    pqm_state_t y;
    y = x;
    if (y.used[p]) begin
      y.free = y.free + FREE_W'(y.pages[p]);
      y.used[p] = 1'b0;
      y.pages[p] = '0;
    end
    return y;
  endfunction : rel_pkt

  function automatic logic [PHYS_W-1:0] phys(input logic [PKT_W-1:0] p,
                                             input logic [SEQ_W-1:0] a);
    return {p, a};
  endfunction : phys

  pqm_fifo u_txq (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .push_i(txq_push), .pop_i(txq_pop),
    .data_i(s_reg.packet_number_register), .data_o(txq_head), .empty_o(txq_empty), .full_o()
  );
  pqm_fifo u_cmpq (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .push_i(cmpq_push), .pop_i(cmpq_pop),
    .data_i(cmpq_din), .data_o(cmpq_head), .empty_o(cmpq_empty), .full_o()
  );
  pqm_fifo u_rxq (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .push_i(rxq_push), .pop_i(rxq_pop),
    .data_i(s_reg.rx_pkt), .data_o(rxq_head), .empty_o(rxq_empty), .full_o()
  );

  assign cmpq_din = s_reg.tx_pkt;
  assign reg_rdata_o = s_reg.rdata;
  assign tx_start_o = s_reg.tx_start;
  assign tx_pkt_o = s_reg.tx_pkt;
  assign rx_active_o = s_reg.rx_act;
  assign rx_pkt_o = s_reg.rx_pkt;
  assign mem_o = s_reg.mem;
  assign rx_overrun_o = s_reg.rx_ovr_p;
  assign allocation_done_flag_o = s_reg.alloc_done;
  assign send_done_o = !cmpq_empty;
  assign send_queue_empty_o = txq_empty;
  assign receive_packet_flag_o = !rxq_empty && s_reg.ctrl[CTL_RXIE];

  always_comb begin
    s_next = s_reg;
    s_next.tx_start = 1'b0;
    s_next.rx_ovr_p = 1'b0;
    s_next.mem.wr = 1'b0;
    txq_push = 1'b0;
    txq_pop = 1'b0;
    cmpq_push = 1'b0;
    cmpq_pop = 1'b0;
    rxq_push = 1'b0;
    rxq_pop = 1'b0;
    rx_go = 1'b0;
    rx_fail = 1'b0;
    ff = first_free(s_reg.used);
    bytes_up = {1'b0, reg_wdata_i[CMD_BYTES_LSB +: BYTES_W]} + 13'h00FF;
    req_pages = bytes_up[PAGE_SHIFT +: PG_W] | {3'h0, bytes_up[BYTES_W] == 1'b0 &&
                bytes_up[PAGE_SHIFT +: PG_W] == 4'h0};
    if (bytes_up[BYTES_W]) begin
      req_pages = 4'hF;
    end
    // Register reads, answered next cycle
    if (reg_rd_i) begin
      case (reg_addr_i)
        REG_ALLOC_RES: s_next.rdata = {24'h0, s_reg.alloc_fail, 1'b0, s_reg.alloc_res};
        REG_PACKET_NUMBER: s_next.rdata = {26'h0, s_reg.packet_number_register};
        REG_FIFO_PORTS: s_next.rdata = {16'h0, rxq_empty, 1'b0, rxq_head,
                                        cmpq_empty, 1'b0, cmpq_head};
        REG_FLAGS: s_next.rdata = {26'h0, s_reg.alloc_pend, s_reg.halt,
                                   receive_packet_flag_o, send_queue_empty_o,
                                   send_done_o, s_reg.alloc_done};
        REG_CTRL: s_next.rdata = {28'h0, s_reg.ctrl};
        REG_RESERVE: s_next.rdata = {22'h0, s_reg.reserve};
        REG_MEMINFO: s_next.rdata = {6'h0, TOTAL_PAGES, 6'h0, s_reg.free};
        default: s_next.rdata = '0;
      endcase
    end else begin
      s_next.rdata = '0;
    end
    // Register writes and commands
    if (reg_wr_i) begin
      case (reg_addr_i)
        REG_CMD: begin
          case (reg_wdata_i[CMD_LSB +: 4])
            CMD_ALLOC: begin
              s_next.alloc_done = 1'b0;
              s_next.alloc_fail = (req_pages > MAX_PKT_PAGES);
              s_next.alloc_pend = (req_pages <= MAX_PKT_PAGES);
              s_next.alloc_pages = req_pages;
            end
            CMD_RELEASE: s_next = rel_pkt(s_next, s_reg.packet_number_register);
            CMD_ENQ_TX: txq_push = 1'b1;
            CMD_RM_REL_RX: begin
              if (!rxq_empty) begin
                rxq_pop = 1'b1;
                s_next = rel_pkt(s_next, rxq_head);
              end
            end
            default: ;
          endcase
        end
        REG_PACKET_NUMBER: s_next.packet_number_register = reg_wdata_i[PKT_W-1:0];
        REG_CTRL: begin
          s_next.ctrl = reg_wdata_i[3:0];
          s_next.halt = 1'b0;
        end
        REG_RESERVE: s_next.reserve = reg_wdata_i[FREE_W-1:0];
        REG_TX_ACK: cmpq_pop = 1'b1;
        default: ;
      endcase
    end
    // New receive packet: needs free memory above the reservation
    if (rx_start_i) begin
      if (s_reg.ctrl[CTL_RX_EN] && !s_reg.rx_act && !s_reg.rx_pend && ff[PKT_W] &&
          s_reg.free > s_reg.reserve) begin
        rx_go = 1'b1;
        s_next.rx_act = 1'b1;
        s_next.rx_pkt = ff[PKT_W-1:0];
        s_next.used[ff[PKT_W-1:0]] = 1'b1;
        s_next.pages[ff[PKT_W-1:0]] = 4'h1;
        s_next.free = s_next.free - 10'h001;
      end else begin
        s_next.rx_ovr_p = 1'b1;
      end
    end
    // Pending transmit allocation, ignores the reservation
    if (s_reg.alloc_pend && !rx_go && ff[PKT_W] &&
        s_reg.free >= FREE_W'(s_reg.alloc_pages)) begin
      s_next.alloc_pend = 1'b0;
      s_next.alloc_done = 1'b1;
      s_next.alloc_res = ff[PKT_W-1:0];
      s_next.used[ff[PKT_W-1:0]] = 1'b1;
      s_next.pages[ff[PKT_W-1:0]] = s_reg.alloc_pages;
      s_next.free = s_next.free - FREE_W'(s_reg.alloc_pages);
    end
    // Receive data: grow by one page when the address leaves held pages
    if (rx_wr_i && s_reg.rx_act) begin
      if ({1'b0, rx_seq_addr_i[SEQ_W-1:OFF_W]} >= s_reg.pages[s_reg.rx_pkt]) begin
        if (s_next.free != 10'h000) begin
          s_next.pages[s_reg.rx_pkt] = s_reg.pages[s_reg.rx_pkt] + 4'h1;
          s_next.free = s_next.free - 10'h001;
        end else begin
          rx_fail = 1'b1;
        end
      end
      if (!rx_fail && !rx_ovr_i) begin
        s_next.mem = '{1'b1, phys(s_reg.rx_pkt, rx_seq_addr_i), rx_data_i};
      end
    end
    if (s_reg.rx_act && (rx_ovr_i || rx_fail)) begin
      s_next = rel_pkt(s_next, s_reg.rx_pkt);
      s_next.rx_act = 1'b0;
      s_next.rx_ovr_p = 1'b1;
    end else if (s_reg.rx_act && rx_end_i) begin
      s_next.rx_act = 1'b0;
      s_next.rx_pend = 1'b1;
      s_next.rx_crc = rx_crc_ok_i;
      s_next.rx_stat = rx_status_i;
      s_next.rx_cnt = rx_count_i;
    end
    // Transmit hand-off
    if (!s_reg.tx_busy && !txq_empty && s_reg.ctrl[CTL_TX_EN] && !s_reg.halt &&
        (full_duplex_i || defer_ok_i)) begin
      s_next.tx_start = 1'b1;
      s_next.tx_busy = 1'b1;
      s_next.tx_pkt = txq_head;
    end
    if (s_reg.tx_busy && !s_reg.tx_pend && tx_done_i) begin
      s_next.tx_pend = 1'b1;
      s_next.tx_fatal = tx_fatal_i;
      s_next.tx_stat = tx_status_i;
    end
    // Status word writes, yielding to receive data
    if (!rx_wr_i) begin
      case (s_reg.st)
        ST_IDLE: begin
          if (s_reg.tx_pend) begin
            s_next.st = ST_TX_STAT;
          end else if (s_reg.rx_pend) begin
            s_next.st = ST_RX_STAT;
          end
        end
        ST_TX_STAT: begin
          s_next.mem = '{1'b1, phys(s_reg.tx_pkt, '0), s_reg.tx_stat};
          txq_pop = 1'b1;
          s_next.tx_pend = 1'b0;
          s_next.tx_busy = 1'b0;
          if (s_reg.ctrl[CTL_AUTO] && !s_reg.tx_fatal) begin
            s_next = rel_pkt(s_next, s_reg.tx_pkt);
          end else begin
            cmpq_push = 1'b1;
            s_next.halt = s_reg.ctrl[CTL_AUTO];
          end
          s_next.st = ST_IDLE;
        end
        ST_RX_STAT: begin
          s_next.mem = '{1'b1, phys(s_reg.rx_pkt, '0), s_reg.rx_stat};
          s_next.st = ST_RX_CNT;
        end
        ST_RX_CNT: begin
          s_next.mem = '{1'b1, phys(s_reg.rx_pkt, 9'h001), s_reg.rx_cnt};
          if (s_reg.rx_crc) begin
            rxq_push = 1'b1;
          end else begin
            s_next = rel_pkt(s_next, s_reg.rx_pkt);
          end
          s_next.rx_pend = 1'b0;
          s_next.st = ST_IDLE;
        end
        default: s_next.st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '{ctrl: CTL_RESET, reserve: RESERVE_RESET, free: TOTAL_PAGES,
                 st: ST_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  sequence rx_word0_s;
    s_reg.st == ST_RX_STAT && !rx_wr_i ##1 !rx_wr_i;
  endsequence
  sequence rx_word1_s;
    mem_o.wr && mem_o.addr == {s_reg.rx_pkt, 9'h000} ##1
    mem_o.wr && mem_o.addr == {s_reg.rx_pkt, 9'h001};
  endsequence

  send_done_q_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    cmpq_push |=> send_done_o) else $error("send done not raised after completion");
  sq_empty_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    txq_push |=> !send_queue_empty_o) else $error("queue empty flag after enqueue");
  tx_gate_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    tx_start_o |-> $past(s_reg.ctrl[CTL_TX_EN]) && $past(full_duplex_i || defer_ok_i))
    else $error("transmit started without permission");
  alloc_done_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(allocation_done_flag_o) |-> s_reg.used[s_reg.alloc_res] && !s_reg.alloc_pend)
    else $error("allocation done without owned packet");
  rx_status_seq_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    rx_word0_s |-> rx_word1_s) else $error("receive status words out of order");
  auto_free_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (s_reg.st == ST_TX_STAT && !rx_wr_i && s_reg.ctrl[CTL_AUTO] && !s_reg.tx_fatal)
    |-> !cmpq_push ##1 !s_reg.used[$past(s_reg.tx_pkt)])
    else $error("successful packet not auto released");
  rx_reserve_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rx_start_i && !s_reg.rx_act && s_reg.free <= s_reg.reserve) |=> !rx_active_o)
    else $error("receive accepted below reservation");
  overrun_drop_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (s_reg.rx_act && rx_ovr_i) |=> rx_overrun_o && !rx_active_o &&
    !s_reg.used[$past(s_reg.rx_pkt)]) else $error("overrun packet not released");
  rx_flag_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rxq_push && s_reg.ctrl[CTL_RXIE]) |=> receive_packet_flag_o)
    else $error("receive flag missing for queued packet");
  free_bound_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    s_reg.free <= TOTAL_PAGES) else $error("free memory above total");
endmodule : pqm_manager

//--- tb/pqm_mac_model.sv
// Behavioural transmit engine facing the manager
module pqm_mac_model (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic tx_start_i,
  input wire logic fatal_i,
  input wire logic [31:0] status_i,
  output logic tx_done_o,
  output logic tx_fatal_o,
  output logic [31:0] tx_status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;
  // Latency follows the status word: prompt and slow answers
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_reg <= 4'h0;
    end else if (tx_start_i) begin
      cnt_reg <= {1'b0, status_i[2:0]} + 4'h2;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
  assign tx_done_o = (cnt_reg == 4'h1);
  assign tx_fatal_o = tx_done_o & fatal_i;
  // Junk on the status lines outside the done pulse
  assign tx_status_o = tx_done_o ? status_i : ~status_i;
endmodule : pqm_mac_model

//--- tb/tb.sv
// Self-checking bench for the packet queue memory manager
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
$display("[FAIL] %s exp %h got %h", n, e, g); end end
`define W(c) begin wt = 0; while (!(c) && wt < 400) begin @(posedge clk); #1; wt++; end \
if (!(c)) begin failures++; results(); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pqm_pkg::*;
  logic clk, rst, we, re, fdx, dok, rxs, rxw, ovr, rxe, crc, fat, tdone, tfat;
  logic tx_start, rx_act, ovro, adone, sdone, sqe, rflag, rd_q;
  logic [7:0] addr;
  logic [8:0] seq;
  logic [31:0] wd, rdat, txst, tstat, rxd, rxst, rxc, last_rd, s;
  logic [5:0] tx_pkt, rx_pkt, p, p2, rp;
  logic [5:0] pk[64];
  pqm_mem_wr_t mem;
  logic [63:0] rq[$];
  logic [46:0] mq[$];
  logic [63:0] r;
  logic [46:0] m;
  int failures, samples_checked, wt, starts, ovrs;

  pqm_manager dut_u (.ref_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(we), .reg_rd_i(re), .reg_rdata_o(rdat), .full_duplex_i(fdx), .defer_ok_i(dok),
    .tx_start_o(tx_start), .tx_pkt_o(tx_pkt), .tx_done_i(tdone), .tx_fatal_i(tfat),
    .tx_status_i(tstat), .rx_start_i(rxs), .rx_active_o(rx_act), .rx_pkt_o(rx_pkt),
    .rx_wr_i(rxw), .rx_seq_addr_i(seq), .rx_data_i(rxd), .rx_ovr_i(ovr), .rx_end_i(rxe),
    .rx_crc_ok_i(crc), .rx_status_i(rxst), .rx_count_i(rxc), .mem_o(mem),
    .rx_overrun_o(ovro), .allocation_done_flag_o(adone), .send_done_o(sdone),
    .send_queue_empty_o(sqe), .receive_packet_flag_o(rflag));
  pqm_mac_model mac_u (.ref_clk_i(clk), .reset_i(rst), .tx_start_i(tx_start), .fatal_i(fat),
    .status_i(txst), .tx_done_o(tdone), .tx_fatal_o(tfat), .tx_status_o(tstat));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nx

  function automatic logic [9:0] pg(input logic [11:0] b);
    return (b == 12'h000) ? 10'h001 : 10'((b + 255) / 256);
  endfunction : pg

  task results;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wd <= d; we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
    rq.push_back({msk, e});
    @(posedge clk);
    addr <= a; re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
  endtask : rd

  task cmd(input logic [3:0] c, input logic [11:0] b);
    wr(REG_CMD, {4'h0, b, 12'h000, c});
  endtask : cmd

  task free_is(input logic [9:0] f);
    rd(REG_MEMINFO, 32'hFFFF_FFFF, {6'h00, TOTAL_PAGES, 6'h00, f});
  endtask : free_is

  task res(output logic [5:0] q);
    rd(REG_ALLOC_RES, 32'h0000_0080, 32'h0000_0000);
    @(posedge clk);
    #1;
    q = last_rd[5:0];
  endtask : res

  task alloc(input logic [11:0] b, output logic [5:0] q);
    cmd(CMD_ALLOC, b);
    @(posedge clk);
    `W(adone === 1'b1)
    res(q);
  endtask : alloc

  task send(input logic [5:0] q);
    wr(REG_PACKET_NUMBER, {26'h0, q});
    cmd(CMD_ENQ_TX, 12'h000);
  endtask : send

  task rx_go;
    @(posedge clk);
    rxs <= 1'b1;
    @(posedge clk);
    rxs <= 1'b0;
  endtask : rx_go

  task rxw_t(input logic [8:0] a);
    s = nx(s);
    mq.push_back({rp, a, s});
    @(posedge clk);
    rxw <= 1'b1; seq <= a; rxd <= s;
    @(posedge clk);
    rxw <= 1'b0;
  endtask : rxw_t

  task rx_fin(input logic c);
    @(posedge clk);
    s = nx(s); rxst <= s; mq.push_back({rp, 9'h000, s});
    s = nx(s); rxc <= s; mq.push_back({rp, 9'h001, s});
    crc <= c; rxe <= 1'b1;
    @(posedge clk);
    rxe <= 1'b0;
  endtask : rx_fin

  // Read data and memory writes are matched against the oldest notes
  always @(posedge clk) begin
    if (rd_q) begin
      r = rq.pop_front();
      last_rd = rdat;
      if (r[63:32] !== 32'h0) `CHK("rdata", r[31:0], rdat & r[63:32])
    end
    rd_q <= re;
    if (mem.wr === 1'b1) begin
      `CHK("mem_note", 1'b1, mq.size() > 0)
      if (mq.size() > 0) begin
        m = mq.pop_front();
        `CHK("mem_wr", m, {mem.addr, mem.data})
      end
    end
    if (tx_start === 1'b1) starts++;
    if (ovro === 1'b1) ovrs++;
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    results();
  end

  initial begin
    {we, re, fdx, dok, rxs, rxw, ovr, rxe, crc, fat} = '0;
    addr = '0; wd = '0; seq = '0; rxd = '0; rxst = '0; rxc = '0; txst = '0;
    s = 32'h6597_169a; rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    free_is(TOTAL_PAGES);
    rd(REG_FLAGS, 32'h0000_003F, 32'h0000_0004);
    rd(8'hFC, 32'hFFFF_FFFF, 32'h0000_0000);
    cmd(CMD_ALLOC, 12'h801);
    rd(REG_ALLOC_RES, 32'h0000_0080, 32'h0000_0080);
    rd(REG_FLAGS, 32'h0000_0021, 32'h0000_0000);
    s = nx(s); txst <= s;
    alloc({1'b0, s[10:0]}, p);
    free_is(TOTAL_PAGES - pg({1'b0, s[10:0]}));
    send(p);
    repeat (6) @(posedge clk);
    `CHK("start", 0, starts)
    rd(REG_FLAGS, 32'h0000_0004, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0001);
    repeat (6) @(posedge clk);
    `CHK("start", 0, starts)
    mq.push_back({p, 9'h000, s});
    dok <= 1'b1;
    `W(sdone === 1'b1)
    `CHK("tx_pkt", p, tx_pkt)
    `CHK("txq_empty", 1'b1, sqe)
    rd(REG_FIFO_PORTS, 32'h0000_00BF, {24'h0, 2'b00, p});
    `CHK("mem_left", 0, mq.size())
    cmd(CMD_RELEASE, 12'h000);
    wr(REG_TX_ACK, 32'h0000_0000);
    @(posedge clk); #1;
    `CHK("sent", 1'b0, sdone)
    free_is(TOTAL_PAGES);
    wr(REG_CTRL, 32'h0000_0005);
    alloc(12'h100, p);
    s = nx(s); txst <= s; mq.push_back({p, 9'h000, s});
    send(p);
    `W(mq.size() == 0)
    repeat (4) @(posedge clk);
    `CHK("sent", 1'b0, sdone)
    free_is(TOTAL_PAGES);
    fat <= 1'b1;
    alloc(12'h100, p);
    alloc(12'h000, p2);
    s = nx(s); txst <= s; mq.push_back({p, 9'h000, s});
    send(p);
    send(p2);
    `W(sdone === 1'b1)
    repeat (6) @(posedge clk);
    `CHK("halted_q", 1'b0, sqe)
    rd(REG_FLAGS, 32'h0000_0010, 32'h0000_0010);
    fat <= 1'b0;
    rd(REG_PACKET_NUMBER, 32'h0000_003F, {26'h0, p2});
    wr(REG_PACKET_NUMBER, {26'h0, p});
    cmd(CMD_RELEASE, 12'h000);
    wr(REG_TX_ACK, 32'h0000_0000);
    wr(REG_PACKET_NUMBER, {26'h0, p2});
    rd(REG_PACKET_NUMBER, 32'h0000_003F, {26'h0, p2});
    mq.push_back({p2, 9'h000, s});
    wr(REG_CTRL, 32'h0000_0005);
    `W(mq.size() == 0)
    repeat (4) @(posedge clk);
    `CHK("sent", 1'b0, sdone)
    `CHK("txq_empty", 1'b1, sqe)
    free_is(TOTAL_PAGES);
    wr(REG_CTRL, 32'h0000_000A);
    rx_go();
    `W(rx_act === 1'b1)
    rp = rx_pkt;
    rxw_t(9'h000);
    rxw_t(9'h040);
    wr(REG_RESERVE, 32'h0000_0200);
    rxw_t(9'h080);
    rx_fin(1'b1);
    `W(rflag === 1'b1)
    rd(REG_FIFO_PORTS, 32'h0000_BF00, {16'h0, 2'b00, rp, 8'h00});
    rx_go();
    repeat (3) @(posedge clk); #1;
    `CHK("refused", 1, ovrs)
    `CHK("rx_act", 1'b0, rx_act)
    wr(REG_CTRL, 32'h0000_0002);
    @(posedge clk); #1;
    `CHK("rflag_off", 1'b0, rflag)
    wr(REG_CTRL, 32'h0000_000A);
    cmd(CMD_RM_REL_RX, 12'h000);
    @(posedge clk); #1;
    `CHK("rflag", 1'b0, rflag)
    free_is(TOTAL_PAGES);
    wr(REG_RESERVE, 32'h0000_0000);
    rx_go();
    `W(rx_act === 1'b1)
    rp = rx_pkt;
    rxw_t(9'h000);
    rx_fin(1'b0);
    repeat (4) @(posedge clk); #1;
    `CHK("bad_crc", 1'b0, rflag)
    free_is(TOTAL_PAGES);
    rx_go();
    `W(rx_act === 1'b1)
    rp = rx_pkt;
    rxw_t(9'h000);
    rxw_t(9'h040);
    @(posedge clk);
    ovr <= 1'b1;
    @(posedge clk);
    ovr <= 1'b0;
    repeat (3) @(posedge clk);
    free_is(TOTAL_PAGES);
    for (int i = 0; i < 64; i++) alloc(12'h800, pk[i]);
    free_is(10'h000);
    cmd(CMD_ALLOC, 12'h800);
    repeat (4) @(posedge clk); #1;
    `CHK("pending", 1'b0, adone)
    rd(REG_FLAGS, 32'h0000_0021, 32'h0000_0020);
    wr(REG_PACKET_NUMBER, {26'h0, pk[0]});
    cmd(CMD_RELEASE, 12'h000);
    `W(adone === 1'b1)
    res(pk[0]);
    for (int i = 0; i < 64; i++) begin
      wr(REG_PACKET_NUMBER, {26'h0, pk[i]});
      cmd(CMD_RELEASE, 12'h000);
    end
    free_is(TOTAL_PAGES);
    repeat (3) @(posedge clk);
    results();
  end
endmodule : tb
